// [ldo_pkg.sv]
// Shared constants for the six-regulator control and fault logic.
// Assumes a single 200 MHz clock; voltages are carried in millivolts.
package ldo_pkg;
    // ---------------------------------------------------------------
    // Sizes and timing
    // ---------------------------------------------------------------
    localparam int NUM_REG = 6;             // Regulators handled
    localparam int CLK_MHZ = 200;           // Clock rate
    localparam int OVERLOAD_US = 8000;      // Overload limit, 8.0 ms
    // Longest time rounds down to whole cycles
    localparam int OVERLOAD_CYC = OVERLOAD_US * CLK_MHZ;
    localparam int TMR_W = 21;              // Counter width for OVERLOAD_CYC
    // ---------------------------------------------------------------
    // Regulator index map
    // ---------------------------------------------------------------
    localparam int IDX_REG1 = 0;
    localparam int IDX_REG2 = 1;
    localparam int IDX_REG3 = 2;
    localparam int IDX_REG4 = 3;
    localparam int IDX_THREE_VOLT = 4;      // three_volt_rail
    localparam int IDX_SD_CARD = 5;         // sd_card_rail
    // ---------------------------------------------------------------
    // Voltage decode constants (mV)
    // ---------------------------------------------------------------
    localparam logic [11:0] MV_HIGH_BASE = 12'h708;  // 1800 mV
    localparam logic [11:0] MV_HIGH_STEP = 12'h064;  // 100 mV
    localparam logic [11:0] MV_LOW_BASE = 12'h320;   // 800 mV
    localparam logic [11:0] MV_LOW_STEP = 12'h032;   // 50 mV
    localparam logic [11:0] MV_2850 = 12'hB22;
    localparam logic [11:0] MV_3000 = 12'hBB8;
    localparam logic [11:0] MV_3150 = 12'hC4E;
    localparam logic [11:0] MV_3300 = 12'hCE4;
    localparam logic [11:0] MV_1800 = 12'h708;
    localparam logic [11:0] MV_1850 = 12'h73A;
    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [5:0] ENABLE_RST = 6'h00;
    localparam logic [5:0] FAULT_RST = 6'h00;
    localparam logic PROTECT_RST = 1'b0;
endpackage

// [ldo_overload_timer.sv]
// Overload duration timer for one regulator.
// Assumes current_limit is already synchronised to clock.
`timescale 1ns/1ps
module ldo_overload_timer
    import ldo_pkg::*;
#(
    parameter int LIMIT_CYC = OVERLOAD_CYC
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic current_limit,   // Regulator is in current limit
    input wire logic running,         // Regulator output is on
    output logic expired              // High once the limit is exceeded
);
    // ---------------------------------------------------------------
    // Counter
    // ---------------------------------------------------------------
    logic [TMR_W-1:0] count_r; // Cycles of continuous overload

    // Restart on clear
    // Count only while the overload persists; any gap restarts at zero.
    always_ff @(posedge clock)
    begin
        if (rst || !current_limit || !running)
        begin
            count_r <= '0;
        end
        else if (count_r != TMR_W'(LIMIT_CYC))
        begin
            count_r <= count_r + 1'b1;
        end
    end

    // Longer than limit
    // Stays high while the overload outlasts the limit, so setting the
    // protect enable during a long overload still shuts the output down.
    assign expired = current_limit && running
        && (count_r >= TMR_W'(LIMIT_CYC - 1));
endmodule

// [ldo_control_fault_logic.sv]
// Control, voltage decode and overload fault logic for six regulators.
// Assumes control bits come from a host-side register file on the same
// clock; current-limit and standby inputs come from analog/pins.
//
// What this block does
// - Overloaded regulator limits current, not voltage
// - Protect enabled: overload past 8 ms disables
// - Shutdown clears enable and raises fault
// - Mask bit hides fault from host
// - Protection enable resets cleared
// - Fault raised on overload regardless of protect
// - Power-up loads voltage codes from OTP
// - First regulator: 1.80 V plus 0.10 V
// - Second regulator: 0.80 V plus 0.05 V
// - Third, fourth: 1.80 V plus 0.10 V
// - Three-volt rail: 2.85/3.00/3.15/3.30 V
// - SD rail range select picks 1.8 V table
// - Enable and standby settings apply immediately
// - Output on when enabled, unless standby-off
// - Disabled regulator gets pull-down discharge
`timescale 1ns/1ps
module ldo_control_fault_logic
    import ldo_pkg::*;
#(
    parameter int N = NUM_REG,
    parameter int LIMIT_CYC = OVERLOAD_CYC
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic power_up_load,
    input wire logic [23:0] otp_regulator_voltage_cfg,
    input wire logic sd_card_rail_range_select,
    input wire logic short_circuit_protect_enable_wr,
    input wire logic short_circuit_protect_enable_in,
    input wire logic [N-1:0] enable_set,
    input wire logic [N-1:0] enable_clear,
    input wire logic [N-1:0] regulator_standby_off_bit,
    input wire logic code_write,
    input wire logic [23:0] code_in,
    input wire logic [N-1:0] regulator_fault_mask,
    input wire logic [N-1:0] fault_clear,
    input wire logic standby_pin,
    input wire logic [N-1:0] current_limit_pin,
    output logic short_circuit_protect_enable,
    output logic [N-1:0] regulator_enable_bit,
    output logic [23:0] regulator_control_reg,
    output logic [N-1:0] regulator_output,
    output logic [N-1:0] pull_down_on,
    output logic [N-1:0] current_regulate,
    output logic [N-1:0] fault_status,
    output logic [N-1:0] regulator_fault_irq,
    output logic fault_any,
    output logic [71:0] set_point_mv
);
    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic [N-1:0] limit_meta_r; // First stage, read only by second
    logic [N-1:0] limit_sync_r; // Usable current-limit level
    logic standby_meta_r;       // First stage of standby event
    logic standby_sync_r;       // Usable standby level
    logic [N-1:0] expired;      // Per-regulator overload timeout

    // Pins are asynchronous to clock, so two stages each
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            limit_meta_r <= '0;
            limit_sync_r <= '0;
            standby_meta_r <= 1'b0;
            standby_sync_r <= 1'b0;
        end
        else
        begin
            limit_meta_r <= current_limit_pin;
            limit_sync_r <= limit_meta_r;
            standby_meta_r <= standby_pin;
            standby_sync_r <= standby_meta_r;
        end
    end

    // ---------------------------------------------------------------
    // Protection enable
    // ---------------------------------------------------------------
    // Cleared at reset
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            short_circuit_protect_enable <= PROTECT_RST;
        end
        else if (short_circuit_protect_enable_wr)
        begin
            short_circuit_protect_enable <= short_circuit_protect_enable_in;
        end
    end

    // ---------------------------------------------------------------
    // Voltage codes
    // ---------------------------------------------------------------
    // Layout: four 4-bit codes in [15:0], then two 2-bit codes; rest unused
    // OTP copy at power-up
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            regulator_control_reg <= 24'h000000;
        end
        else if (power_up_load)
        begin
            // OTP copy takes priority over a host write in the same cycle
            regulator_control_reg <= {4'h0, otp_regulator_voltage_cfg[19:0]};
        end
        else if (code_write)
        begin
            regulator_control_reg <= {4'h0, code_in[19:0]};
        end
    end

    // ---------------------------------------------------------------
    // Enables and overload shutdown
    // ---------------------------------------------------------------
    // Immediate enable
    // Shutdown clears enable
    // Shutdown beats a host enable arriving in the same cycle.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            regulator_enable_bit <= ENABLE_RST;
        end
        else
        begin
            regulator_enable_bit <= (regulator_enable_bit | enable_set)
                & ~enable_clear
                & ~(expired & {N{short_circuit_protect_enable}});
        end
    end

    // ---------------------------------------------------------------
    // Fault latch
    // ---------------------------------------------------------------
    // Fault on overload
    // Latched until cleared
    // Hardware set wins over a host clear in the same cycle.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            fault_status <= FAULT_RST;
        end
        else
        begin
            fault_status <= (fault_status & ~fault_clear)
                | (limit_sync_r & regulator_output) | expired;
        end
    end

    assign regulator_fault_irq = fault_status & ~regulator_fault_mask;
    assign fault_any = |regulator_fault_irq;

    // ---------------------------------------------------------------
    // Per-regulator output control
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : gen_reg
            assign regulator_output[g] = regulator_enable_bit[g]
                && !(regulator_standby_off_bit[g] && standby_sync_r);
            assign pull_down_on[g] = !regulator_output[g];
            assign current_regulate[g] = regulator_output[g] && limit_sync_r[g];

            ldo_overload_timer #(
                .LIMIT_CYC(LIMIT_CYC)
            ) u_timer (
                .clock(clock),
                .rst(rst),
                .current_limit(limit_sync_r[g]),
                .running(regulator_output[g]),
                .expired(expired[g])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // Set-point decode
    // ---------------------------------------------------------------
    // Linear 4-bit code to millivolts
    function automatic logic [11:0] lin_mv(
        input logic [3:0] code,
        input logic [11:0] base,
        input logic [11:0] step
    );
        logic [15:0] prod;
        prod = 16'(code) * 16'(step);
        return base + prod[11:0];
    endfunction

    // Two-bit 2.85..3.30 V table
    function automatic logic [11:0] hi_mv(input logic [1:0] code);
        logic [11:0] v;
        unique case (code)
            2'h0: v = MV_2850;
            2'h1: v = MV_3000;
            2'h2: v = MV_3150;
            2'h3: v = MV_3300;
        endcase
        return v;
    endfunction

    // Registered so the set points are clean data outputs
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            set_point_mv <= '0;
        end
        else
        begin
            set_point_mv[11:0] <= lin_mv(regulator_control_reg[3:0],
                MV_HIGH_BASE, MV_HIGH_STEP);
            set_point_mv[23:12] <= lin_mv(regulator_control_reg[7:4],
                MV_LOW_BASE, MV_LOW_STEP);
            set_point_mv[35:24] <= lin_mv(regulator_control_reg[11:8],
                MV_HIGH_BASE, MV_HIGH_STEP);
            set_point_mv[47:36] <= lin_mv(regulator_control_reg[15:12],
                MV_HIGH_BASE, MV_HIGH_STEP);
            set_point_mv[59:48] <= hi_mv(regulator_control_reg[17:16]);
            if (!sd_card_rail_range_select)
            begin
                set_point_mv[71:60] <= hi_mv(regulator_control_reg[19:18]);
            end
            else if (regulator_control_reg[19:18] == 2'h3)
            begin
                set_point_mv[71:60] <= MV_1850;
            end
            else
            begin
                set_point_mv[71:60] <= MV_1800;
            end
        end
    end
endmodule

// [load_model.sv]
// Load model standing on the six regulator outputs.
// Assumes the bench sets overload levels between clock edges.
`timescale 1ns/1ps
module load_model
(
    input wire logic [5:0] regulator_output, // 1 = regulator on
    input wire logic [5:0] overload, // Bench asks for a heavy load
    output logic [5:0] current_limit_pin // Limit flag back to the block
);
    // ----
    // Limit flag
    // ----
    // An off regulator sources no current, so it can never hit its limit
    assign current_limit_pin = overload & regulator_output;
endmodule

// [ldo_control_fault_logic_asserts.sv]
// Checker for the regulator control and fault block.
// Assumes it is bound to the block's top module.
`timescale 1ns/1ps
module ldo_control_fault_logic_asserts
    import ldo_pkg::*;
#(
    parameter int N = NUM_REG,
    parameter int LIMIT_CYC = OVERLOAD_CYC
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic power_up_load,
    input wire logic [23:0] otp_regulator_voltage_cfg,
    input wire logic code_write,
    input wire logic [23:0] code_in,
    input wire logic [N-1:0] enable_clear,
    input wire logic [N-1:0] regulator_fault_mask,
    input wire logic [N-1:0] fault_clear,
    input wire logic short_circuit_protect_enable,
    input wire logic [N-1:0] regulator_enable_bit,
    input wire logic [23:0] regulator_control_reg,
    input wire logic [N-1:0] regulator_output,
    input wire logic [N-1:0] pull_down_on,
    input wire logic [N-1:0] current_regulate,
    input wire logic [N-1:0] fault_status,
    input wire logic [N-1:0] regulator_fault_irq,
    input wire logic fault_any,
    input wire logic [71:0] set_point_mv
);
    // ----
    // Clocking and sequences
    // ----
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // A code write that the OTP load does not override
    sequence s_code_wr;
        code_write && !power_up_load;
    endsequence
    a_code_apply: assert property (s_code_wr |=>
        regulator_control_reg[19:0] == $past(code_in[19:0]) ##1
        set_point_mv[11:0] == 12'h708 + 12'h064 * $past(regulator_control_reg[3:0]))
        else $error("code write not applied");
    a_otp_load: assert property (power_up_load |=>
        regulator_control_reg[19:0] == $past(otp_regulator_voltage_cfg[19:0]))
        else $error("otp codes not loaded");
    a_off_disabled: assert property (~|(regulator_output & ~regulator_enable_bit))
        else $error("output on while disabled");
    a_pull_down: assert property ((pull_down_on == ~regulator_output)
        && ~|(~regulator_enable_bit & ~pull_down_on))
        else $error("pull-down wrong");
    a_irq_mask: assert property (
        regulator_fault_irq == (fault_status & ~regulator_fault_mask)
        && fault_any == |(fault_status & ~regulator_fault_mask))
        else $error("fault irq mask wrong");
    a_protect_rst: assert property ($fell(rst) |-> !short_circuit_protect_enable)
        else $error("protect enable not cleared");
    a_fault_set: assert property ((|current_regulate) |=>
        ~|($past(current_regulate) & ~fault_status))
        else $error("overload fault missing");
    a_fault_hold: assert property (!$past(rst) |->
        ~|($past(fault_status) & ~fault_status & ~$past(fault_clear)))
        else $error("fault dropped without clear");
    // Only a clear or a protected overload may drop an enable bit
    a_shutdown_cause: assert property (!$past(rst) |->
        ~|($past(regulator_enable_bit) & ~regulator_enable_bit & ~$past(enable_clear)
        & ~({N{$past(short_circuit_protect_enable)}} & fault_status)))
        else $error("enable dropped without cause");
endmodule
bind ldo_control_fault_logic ldo_control_fault_logic_asserts #(.N(N), .LIMIT_CYC(LIMIT_CYC))
    chk_i (.clock, .rst, .power_up_load, .otp_regulator_voltage_cfg, .code_write, .code_in,
    .enable_clear, .regulator_fault_mask, .fault_clear, .short_circuit_protect_enable,
    .regulator_enable_bit, .regulator_control_reg, .regulator_output, .pull_down_on,
    .current_regulate, .fault_status, .regulator_fault_irq, .fault_any, .set_point_mv);

// [testbench.sv]
// Self-checking bench for the regulator control and fault block.
// Assumes the package, design, load model and checker compile first.
`timescale 1ns/1ps
module testbench;
    import ldo_pkg::*;
    localparam int LIM = 20; // Short overload limit keeps the run brief
    `define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
    logic clock = 1'b0, rst = 1'b1, power_up_load = 1'b0, code_write = 1'b0;
    logic sd_card_rail_range_select = 1'b0, standby_pin = 1'b0, fault_any;
    logic short_circuit_protect_enable_wr = 1'b0, short_circuit_protect_enable_in = 1'b0;
    logic short_circuit_protect_enable;
    logic [5:0] enable_set = 6'h00, enable_clear = 6'h00, regulator_standby_off_bit = 6'h00;
    logic [5:0] regulator_fault_mask = 6'h00, fault_clear = 6'h00, overload = 6'h00;
    logic [5:0] current_limit_pin, regulator_enable_bit, regulator_output, pull_down_on;
    logic [5:0] current_regulate, fault_status, regulator_fault_irq;
    logic [23:0] otp_regulator_voltage_cfg = 24'h000000, code_in = 24'h000000;
    logic [23:0] regulator_control_reg;
    logic [71:0] set_point_mv;
    logic [3:0] k;
    logic [11:0] v2;
    int n_errors = 0, n_tests = 0, cycles = 0;
    ldo_control_fault_logic #(.LIMIT_CYC(LIM)) ldo_control_fault_logic_i (.clock, .rst,
        .power_up_load, .otp_regulator_voltage_cfg, .sd_card_rail_range_select,
        .short_circuit_protect_enable_wr, .short_circuit_protect_enable_in, .enable_set,
        .enable_clear, .regulator_standby_off_bit, .code_write, .code_in,
        .regulator_fault_mask, .fault_clear, .standby_pin, .current_limit_pin,
        .short_circuit_protect_enable, .regulator_enable_bit, .regulator_control_reg,
        .regulator_output, .pull_down_on, .current_regulate, .fault_status,
        .regulator_fault_irq, .fault_any, .set_point_mv);
    load_model load_model_i (.regulator_output, .overload, .current_limit_pin);
    // ----
    // Clock, timeout, helpers
    // ----
    initial
    begin
        forever #2.5 clock = ~clock;
    end
    // Whole run needs about two hundred cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            end_sim;
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic end_sim;
        $display("Errors: %0d Checks: %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    // Every code of every field, SD rail under both ranges
    task automatic t_codes;
        for (int i = 0; i < 32; i++)
        begin
            k = i[3:0];
            sd_card_rail_range_select = i[4];
            code_in = {4'h0, k[1:0], k[1:0], k, k, k, k};
            code_write = 1'b1;
            cyc(1);
            code_write = 1'b0;
            cyc(1);
            v2 = 12'hB22 + 12'h096 * {10'h000, k[1:0]};
            `CHK(regulator_control_reg, code_in)
            `CHK(set_point_mv[11:0], (12'h708 + 12'h064 * {8'h00, k}))
            `CHK(set_point_mv[23:12], (12'h320 + 12'h032 * {8'h00, k}))
            `CHK(set_point_mv[47:24], ({2{12'h708 + 12'h064 * {8'h00, k}}}))
            `CHK(set_point_mv[59:48], v2)
            `CHK(set_point_mv[71:60], i[4] ? (k[1:0] == 2'h3 ? 12'h73A : 12'h708) : v2)
        end
    endtask
    // OTP load beats a code write in the same cycle; clear beats set
    task automatic t_otp_standby;
        otp_regulator_voltage_cfg = 24'h0ABCDE;
        power_up_load = 1'b1;
        code_write = 1'b1;
        regulator_standby_off_bit = 6'h15;
        enable_set = 6'h3F;
        enable_clear = 6'h01;
        cyc(1);
        power_up_load = 1'b0;
        code_write = 1'b0;
        enable_set = 6'h00;
        enable_clear = 6'h00;
        `CHK(regulator_control_reg, 24'h0ABCDE)
        `CHK(regulator_enable_bit, 6'h3E)
        standby_pin = 1'b1;
        cyc(3);
        `CHK(regulator_output, 6'h2A)
        `CHK(pull_down_on, 6'h15)
        standby_pin = 1'b0;
        cyc(3);
        `CHK(regulator_output, 6'h3E)
    endtask
    // Masked overload with protection off, clear tried mid-overload
    task automatic t_fault;
        regulator_fault_mask = 6'h02;
        overload = 6'h02;
        cyc(4);
        `CHK(current_regulate, 6'h02)
        `CHK(fault_status, 6'h02)
        `CHK(regulator_fault_irq, 6'h00)
        fault_clear = 6'h02;
        cyc(1);
        fault_clear = 6'h00;
        cyc(LIM + 8);
        `CHK(regulator_enable_bit, 6'h3E)
        regulator_fault_mask = 6'h00;
        cyc(1);
        `CHK(regulator_fault_irq, 6'h02)
        `CHK(fault_any, 1'b1)
        overload = 6'h00;
        cyc(5);
        `CHK(fault_status, 6'h02)
        fault_clear = 6'h02;
        cyc(1);
        fault_clear = 6'h00;
        `CHK(fault_status, 6'h00)
    endtask
    // Broken overloads restart the timer; a long one shuts down
    task automatic t_shutdown;
        short_circuit_protect_enable_in = 1'b1;
        short_circuit_protect_enable_wr = 1'b1;
        cyc(1);
        short_circuit_protect_enable_wr = 1'b0;
        `CHK(short_circuit_protect_enable, 1'b1)
        repeat (2)
        begin
            overload = 6'h08;
            cyc(LIM - 4);
            overload = 6'h00;
            cyc(4);
        end
        `CHK(regulator_enable_bit, 6'h3E)
        fault_clear = 6'h08;
        cyc(1);
        fault_clear = 6'h00;
        `CHK(fault_status, 6'h00)
        overload = 6'h08;
        cyc(LIM);
        `CHK(regulator_enable_bit, 6'h3E)
        cyc(8);
        `CHK(regulator_enable_bit, 6'h36)
        `CHK(fault_status[3], 1'b1)
        `CHK(pull_down_on[3], 1'b1)
    endtask
    // ----
    // Main sequence
    // ----
    initial
    begin
        cyc(12);
        `CHK(short_circuit_protect_enable, 1'b0)
        `CHK(pull_down_on, 6'h3F)
        rst = 1'b0;
        t_codes;
        t_otp_standby;
        t_fault;
        t_shutdown;
        end_sim;
    end
endmodule
